// ==== rtl/lls_latency_table.sv ====
// Per-tag table of in-flight loads: start time, address and measured latency.
`timescale 1ns/10ps
module lls_latency_table
    import lls_pkg::*;
#(
    parameter int TAGS = 16,
    parameter int LAT_W = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic issue_valid,
    input wire lls_issue_s issue,
    input wire logic done_valid,
    input wire lls_done_s done,
    input wire logic [3:0] read_tag,
    output logic [LAT_W-1:0] read_latency,
    output logic [LLS_ADDR_W-1:0] read_address,
    output logic [LLS_SRC_W-1:0] read_source
);

    logic [LAT_W-1:0] now_q, now_d;
    logic [LAT_W-1:0] start_q [TAGS];
    logic [LAT_W-1:0] start_d [TAGS];
    logic [LAT_W-1:0] lat_q [TAGS];
    logic [LAT_W-1:0] lat_d [TAGS];
    logic [LLS_ADDR_W-1:0] addr_q [TAGS];
    logic [LLS_ADDR_W-1:0] addr_d [TAGS];
    logic [LLS_SRC_W-1:0] src_q [TAGS];
    logic [LLS_SRC_W-1:0] src_d [TAGS];
    logic [LLS_SRC_W-1:0] done_source;

    lls_source_encode u_encode (
        .outcome(done.outcome),
        .source(done_source)
    );

    // ========================================================================
    // Table update
    // ========================================================================
    // The address is latched at execution, so a load that overwrites its own
    // base register still reports the address it actually used.
    always_comb begin
        now_d = now_q + LAT_W'(1);
        for (int i = 0; i < TAGS; i++) begin
            start_d[i] = start_q[i];
            lat_d[i] = lat_q[i];
            addr_d[i] = addr_q[i];
            src_d[i] = src_q[i];
        end
        if (issue_valid) begin
            start_d[issue.tag] = now_q;
            addr_d[issue.tag] = issue.address;
        end
        if (done_valid) begin
            lat_d[done.tag] = now_q - start_q[done.tag];
            src_d[done.tag] = done_source;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            now_q <= '0;
            for (int i = 0; i < TAGS; i++) begin
                start_q[i] <= '0;
                lat_q[i] <= '0;
                addr_q[i] <= '0;
                src_q[i] <= '0;
            end
        end else begin
            now_q <= now_d;
            start_q <= start_d;
            lat_q <= lat_d;
            addr_q <= addr_d;
            src_q <= src_d;
        end
    end

    assign read_latency = lat_q[read_tag];
    assign read_address = addr_q[read_tag];
    assign read_source = src_q[read_tag];

endmodule

// ==== rtl/lls_load_latency_sampler.sv ====
// Top of the load latency sampler: threshold register, counters, arming and record writer.
`timescale 1ns/10ps
module lls_load_latency_sampler
    import lls_pkg::*;
#(
    parameter int COUNTERS = 4,
    parameter int TAGS = 16
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [11:0] reg_address,
    input wire logic [63:0] reg_write_data,
    output logic [63:0] reg_read_data,
    input wire logic [COUNTERS-1:0] counter_enable,
    input wire logic [COUNTERS*16-1:0] counter_select,
    input wire logic counter_load,
    input wire logic [1:0] counter_load_index,
    input wire logic [LLS_COUNT_W-1:0] counter_load_value,
    input wire logic issue_valid,
    input wire lls_issue_s issue,
    input wire logic done_valid,
    input wire lls_done_s done,
    input wire logic retire_valid,
    input wire lls_retire_s retire,
    output logic rec_valid,
    output lls_rec_word_s rec_word,
    input wire logic rec_ready,
    output logic perf_monitor_interrupt,
    output logic [COUNTERS-1:0] counter_overflow,
    output logic [COUNTERS-1:0] capture_armed
);

    typedef enum logic [1:0] {
        LLS_IDLE,
        LLS_WRITE,
        LLS_SIGNAL
    } lls_state_e;

    // Counter selection match: event code in the low byte, unit mask above it.
    function automatic logic lls_selected(input logic [15:0] sel);
        return (sel[7:0] == LLS_EVENT_CODE) && (sel[15:8] == LLS_UNIT_MASK);
    endfunction

    logic [LLS_THRESHOLD_W-1:0] threshold_q, threshold_d;
    logic [LLS_COUNT_W-1:0] count_q [COUNTERS];
    logic [LLS_COUNT_W-1:0] count_d [COUNTERS];
    logic [COUNTERS-1:0] armed_q, armed_d;
    logic [COUNTERS-1:0] ovf_q, ovf_d;
    lls_state_e state_q, state_d;
    logic [1:0] word_q, word_d;
    logic [LLS_ADDR_W-1:0] cap_addr_q, cap_addr_d;
    logic [LLS_SRC_W-1:0] cap_src_q, cap_src_d;
    logic [LLS_IP_W-1:0] cap_ip_q, cap_ip_d;
    logic rec_valid_q, rec_valid_d;
    lls_rec_word_s rec_word_q, rec_word_d;
    logic pmi_q, pmi_d;
    logic [63:0] rd_q, rd_d;
    logic [LLS_THRESHOLD_W-1:0] ret_latency;
    logic [LLS_ADDR_W-1:0] ret_address;
    logic [LLS_SRC_W-1:0] ret_source;
    logic qualifies;
    logic take_sample;

    // ========================================================================
    // In-flight load table
    // ========================================================================
    lls_latency_table #(
        .TAGS(TAGS),
        .LAT_W(LLS_THRESHOLD_W)
    ) u_table (
        .clock(clock),
        .reset_n(reset_n),
        .issue_valid(issue_valid),
        .issue(issue),
        .done_valid(done_valid),
        .done(done),
        .read_tag(retire.tag),
        .read_latency(ret_latency),
        .read_address(ret_address),
        .read_source(ret_source)
    );

    // A retiring load qualifies only when strictly slower than the threshold.
    assign qualifies = retire_valid && (ret_latency > threshold_q);

    // ========================================================================
    // Threshold register
    // ========================================================================
    // A single register feeds every counter, so all of them see one value.
    always_comb begin
        threshold_d = threshold_q;
        rd_d = '0;
        if (reg_write && reg_address == LLS_THRESHOLD_ADDR) begin
            threshold_d = reg_write_data[LLS_THRESHOLD_W-1:0];
        end
        if (reg_read && reg_address == LLS_THRESHOLD_ADDR) begin
            rd_d = {48'h0, threshold_q};
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            threshold_q <= LLS_THRESHOLD_RESET;
            rd_q <= '0;
        end else begin
            threshold_q <= threshold_d;
            rd_q <= rd_d;
        end
    end

    // ========================================================================
    // Counters and arming
    // ========================================================================
    // While a record is in progress a new arming capture waits; the sample is
    // simply skipped, like the shadow after an overflow in real hardware.
    always_comb begin
        take_sample = 1'b0;
        armed_d = armed_q;
        ovf_d = '0;
        for (int i = 0; i < COUNTERS; i++) begin
            count_d[i] = count_q[i];
            if (counter_enable[i] && lls_selected(counter_select[i*16 +: 16])) begin
                if (qualifies) begin
                    if (armed_q[i]) begin
                        if (state_q == LLS_IDLE) begin
                            take_sample = 1'b1;
                            armed_d[i] = 1'b0;
                        end
                    end
                    count_d[i] = count_q[i] + LLS_COUNT_W'(1);
                    if (&count_q[i]) begin
                        ovf_d[i] = 1'b1;
                        armed_d[i] = 1'b1;
                    end
                end
            end
        end
        if (counter_load) begin
            count_d[counter_load_index] = counter_load_value;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < COUNTERS; i++) begin
                count_q[i] <= '0;
            end
            armed_q <= '0;
            ovf_q <= '0;
        end else begin
            count_q <= count_d;
            armed_q <= armed_d;
            ovf_q <= ovf_d;
        end
    end

    // ========================================================================
    // Record writer
    // ========================================================================
    // Words leave one at a time; the buffer may stall with rec_ready low.
    always_comb begin
        state_d = state_q;
        word_d = word_q;
        cap_addr_d = cap_addr_q;
        cap_src_d = cap_src_q;
        cap_ip_d = cap_ip_q;
        rec_valid_d = rec_valid_q;
        rec_word_d = rec_word_q;
        pmi_d = 1'b0;
        case (state_q)
            LLS_IDLE: begin
                if (take_sample) begin
                    cap_addr_d = ret_address;
                    cap_src_d = ret_source;
                    cap_ip_d = retire.next_ip;
                    word_d = LLS_WORD_LATENCY;
                    rec_valid_d = 1'b1;
                    rec_word_d.index = LLS_WORD_LATENCY;
                    rec_word_d.data = {48'h0, ret_latency};
                    state_d = LLS_WRITE;
                end
            end
            LLS_WRITE: begin
                if (rec_ready) begin
                    word_d = word_q + 2'h1;
                    rec_word_d.index = word_q + 2'h1;
                    case (word_q)
                        LLS_WORD_LATENCY: begin
                            rec_word_d.data = {16'h0, cap_addr_q};
                        end
                        LLS_WORD_ADDRESS: begin
                            rec_word_d.data = {60'h0, cap_src_q};
                        end
                        LLS_WORD_SOURCE: begin
                            rec_word_d.data = {16'h0, cap_ip_q};
                        end
                        default: begin
                            rec_valid_d = 1'b0;
                            state_d = LLS_SIGNAL;
                        end
                    endcase
                end
            end
            LLS_SIGNAL: begin
                pmi_d = 1'b1;
                state_d = LLS_IDLE;
            end
            default: begin
                state_d = LLS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= LLS_IDLE;
            word_q <= '0;
            cap_addr_q <= '0;
            cap_src_q <= '0;
            cap_ip_q <= '0;
            rec_valid_q <= 1'b0;
            rec_word_q <= '0;
            pmi_q <= 1'b0;
        end else begin
            state_q <= state_d;
            word_q <= word_d;
            cap_addr_q <= cap_addr_d;
            cap_src_q <= cap_src_d;
            cap_ip_q <= cap_ip_d;
            rec_valid_q <= rec_valid_d;
            rec_word_q <= rec_word_d;
            pmi_q <= pmi_d;
        end
    end

    assign reg_read_data = rd_q;
    assign rec_valid = rec_valid_q;
    assign rec_word = rec_word_q;
    assign perf_monitor_interrupt = pmi_q;
    assign counter_overflow = ovf_q;
    assign capture_armed = armed_q;

endmodule

// ==== rtl/lls_pkg.sv ====
// Package with constants, encodings and carrier types of the load latency sampler.
package lls_pkg;

    // ========================================================================
    // Register map and event selection
    // ========================================================================
    localparam logic [11:0] LLS_THRESHOLD_ADDR = 12'h3f6;
    localparam int LLS_THRESHOLD_W = 16;
    localparam logic [15:0] LLS_THRESHOLD_RESET = 16'h0000;
    localparam logic [7:0] LLS_EVENT_CODE = 8'h0b;
    localparam logic [7:0] LLS_UNIT_MASK = 8'h10;
    localparam int LLS_COUNT_W = 48;
    localparam int LLS_ADDR_W = 48;
    localparam int LLS_IP_W = 48;
    localparam int LLS_SRC_W = 4;
    localparam int LLS_SRC_FIELD_W = 16;
    localparam int LLS_REC_WORDS = 4;

    // ========================================================================
    // Data-source codes
    // ========================================================================
    localparam logic [3:0] LLS_SRC_L3_MISS_UNKNOWN = 4'h0;
    localparam logic [3:0] LLS_SRC_L1_HIT = 4'h1;
    localparam logic [3:0] LLS_SRC_FILL_BUFFER = 4'h2;
    localparam logic [3:0] LLS_SRC_L2_HIT = 4'h3;
    localparam logic [3:0] LLS_SRC_L3_HIT_NO_SNOOP = 4'h4;
    localparam logic [3:0] LLS_SRC_L3_HIT_CLEAN_SNOOP = 4'h5;
    localparam logic [3:0] LLS_SRC_L3_HIT_MODIFIED = 4'h6;
    localparam logic [3:0] LLS_SRC_RESERVED_7 = 4'h7;
    localparam logic [3:0] LLS_SRC_REMOTE_FORWARD = 4'h8;
    localparam logic [3:0] LLS_SRC_RESERVED_9 = 4'h9;
    localparam logic [3:0] LLS_SRC_LOCAL_MEM_SHARED = 4'ha;
    localparam logic [3:0] LLS_SRC_REMOTE_MEM_SHARED = 4'hb;
    localparam logic [3:0] LLS_SRC_LOCAL_MEM_EXCL = 4'hc;
    localparam logic [3:0] LLS_SRC_REMOTE_MEM_EXCL = 4'hd;
    localparam logic [3:0] LLS_SRC_IO = 4'he;
    localparam logic [3:0] LLS_SRC_UNCACHEABLE = 4'hf;

    // Record word indices.
    localparam logic [1:0] LLS_WORD_LATENCY = 2'h0;
    localparam logic [1:0] LLS_WORD_ADDRESS = 2'h1;
    localparam logic [1:0] LLS_WORD_SOURCE = 2'h2;
    localparam logic [1:0] LLS_WORD_IP = 2'h3;

    // ========================================================================
    // Carrier types
    // ========================================================================
    // Hierarchy outcome of a load, as reported by the memory side.
    typedef struct packed {
        logic l1_hit;
        logic fill_buffer_hit;
        logic l2_hit;
        logic l3_hit;
        logic snooped;
        logic snoop_modified;
        logic remote_forward;
        logic local_home;
        logic from_memory;
        logic go_exclusive;
        logic io_request;
        logic uncacheable;
    } lls_outcome_s;

    // Load issue information, presented at execution.
    typedef struct packed {
        logic [3:0] tag;
        logic [LLS_ADDR_W-1:0] address;
    } lls_issue_s;

    // Load completion, presented when data is delivered.
    typedef struct packed {
        logic [3:0] tag;
        lls_outcome_s outcome;
    } lls_done_s;

    // Retirement of a load, with the following instruction pointer.
    typedef struct packed {
        logic [3:0] tag;
        logic [LLS_IP_W-1:0] next_ip;
    } lls_retire_s;

    // One precise sample record word.
    typedef struct packed {
        logic [1:0] index;
        logic [63:0] data;
    } lls_rec_word_s;

endpackage

// ==== rtl/lls_source_encode.sv ====
// Combinational encoder from hierarchy outcome to the four-bit data-source code.
`timescale 1ns/10ps
module lls_source_encode
    import lls_pkg::*;
(
    input wire lls_outcome_s outcome,
    output logic [LLS_SRC_W-1:0] source
);

    // ========================================================================
    // Priority encode
    // ========================================================================
    // Special request kinds win over any cache outcome; reserved codes never appear.
    always_comb begin
        source = LLS_SRC_L3_MISS_UNKNOWN;
        if (outcome.uncacheable) begin
            source = LLS_SRC_UNCACHEABLE;
        end else if (outcome.io_request) begin
            source = LLS_SRC_IO;
        end else if (outcome.l1_hit) begin
            source = LLS_SRC_L1_HIT;
        end else if (outcome.fill_buffer_hit) begin
            source = LLS_SRC_FILL_BUFFER;
        end else if (outcome.l2_hit) begin
            source = LLS_SRC_L2_HIT;
        end else if (outcome.l3_hit) begin
            if (!outcome.snooped) begin
                source = LLS_SRC_L3_HIT_NO_SNOOP;
            end else if (outcome.snoop_modified) begin
                source = LLS_SRC_L3_HIT_MODIFIED;
            end else begin
                source = LLS_SRC_L3_HIT_CLEAN_SNOOP;
            end
        end else if (outcome.remote_forward && outcome.local_home) begin
            source = LLS_SRC_REMOTE_FORWARD;
        end else if (outcome.from_memory) begin
            if (outcome.go_exclusive) begin
                source = outcome.local_home ? LLS_SRC_LOCAL_MEM_EXCL
                                            : LLS_SRC_REMOTE_MEM_EXCL;
            end else begin
                source = outcome.local_home ? LLS_SRC_LOCAL_MEM_SHARED
                                            : LLS_SRC_REMOTE_MEM_SHARED;
            end
        end
    end

endmodule

// ==== verif/lls_load_latency_sampler_tb_top.sv ====
// Self-checking testbench of the load latency sampler.
`timescale 1ns/10ps
module lls_load_latency_sampler_tb_top
    import lls_pkg::*;
;
    logic clock, reset_n, reg_write, reg_read, counter_load, rec_ready;
    logic [11:0] reg_address;
    logic [63:0] reg_write_data, reg_read_data, v;
    logic [1:0] counter_load_index;
    logic [47:0] counter_load_value;
    logic issue_valid, done_valid, retire_valid, rec_valid, perf_monitor_interrupt;
    lls_issue_s issue;
    lls_done_s done;
    lls_retire_s retire;
    lls_rec_word_s rec_word;
    logic [3:0] counter_overflow, capture_armed, ovf_seen;
    logic rec_seen;
    logic [63:0] exp_w [4];
    int num_errors = 0, checks = 0, irq_count = 0, cycles = 0;
    // Codes and the hierarchy outcome bits that produce them.
    logic [3:0] code_tab [14] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'ha, 4'hb,
        4'hc, 4'hd, 4'he, 4'hf};
    logic [11:0] oc_tab [14] = '{12'h000, 12'h800, 12'h400, 12'h200, 12'h100, 12'h180, 12'h1c0,
        12'h030, 12'h018, 12'h008, 12'h01c, 12'h00c, 12'h002, 12'h001};

    lls_load_latency_sampler dut_u (.clock(clock), .reset_n(reset_n), .reg_write(reg_write),
        .reg_read(reg_read), .reg_address(reg_address), .reg_write_data(reg_write_data),
        .reg_read_data(reg_read_data), .counter_enable(4'b1100),
        .counter_select(64'h100b_000b_0000_0000), .counter_load(counter_load),
        .counter_load_index(counter_load_index), .counter_load_value(counter_load_value),
        .issue_valid(issue_valid), .issue(issue), .done_valid(done_valid), .done(done),
        .retire_valid(retire_valid), .retire(retire), .rec_valid(rec_valid),
        .rec_word(rec_word), .rec_ready(rec_ready),
        .perf_monitor_interrupt(perf_monitor_interrupt),
        .counter_overflow(counter_overflow), .capture_armed(capture_armed));
    lls_load_pipe_model model_u (.clock(clock), .issue_valid(issue_valid), .issue(issue),
        .done_valid(done_valid), .done(done), .retire_valid(retire_valid), .retire(retire));

    // ========================================================================
    // Clock, monitors and hang guard
    // ========================================================================
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    // Sticky monitors, sampled just after each rising edge once the outputs have settled.
    always @(posedge clock) #1 begin
        ovf_seen = ovf_seen | counter_overflow;
        rec_seen = rec_seen | rec_valid;
        irq_count = irq_count + int'(perf_monitor_interrupt);
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [63:0] d);
        @(negedge clock);
        reg_write = 1'b1;
        reg_address = a;
        reg_write_data = d;
        @(negedge clock);
        reg_write = 1'b0;
    endtask
    task automatic reg_rd(input logic [11:0] a, output logic [63:0] d);
        @(negedge clock);
        reg_read = 1'b1;
        reg_address = a;
        @(negedge clock);
        d = reg_read_data;
        reg_read = 1'b0;
    endtask
    task automatic cnt_load(input logic [1:0] idx);
        @(negedge clock);
        counter_load = 1'b1;
        counter_load_index = idx;
        counter_load_value = 48'hffff_ffff_ffff;
        @(negedge clock);
        counter_load = 1'b0;
        ovf_seen = 4'h0;
        rec_seen = 1'b0;
    endtask
    // Takes one record, stalling the buffer on the second word.
    task automatic get_rec();
        int n;
        for (int i = 0; i < 4; i++) begin
            n = 0;
            while (rec_valid !== 1'b1 && n < 50) begin
                @(negedge clock);
                n++;
            end
            if (i == 1) begin
                rec_ready = 1'b0;
                @(negedge clock);
            end
            rec_ready = 1'b1;
            @(posedge clock);
            check({62'h0, rec_word.index}, 64'(i));
            check(rec_word.data, exp_w[i]);
            @(negedge clock);
        end
        rec_ready = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    initial begin
        {reset_n, reg_write, reg_read, counter_load, rec_ready} = 5'h0;
        {reg_address, reg_write_data, counter_load_index, counter_load_value} = '0;
        repeat (20) @(negedge clock);
        reset_n = 1'b1;
        reg_rd(LLS_THRESHOLD_ADDR, v);
        check(v, {48'h0, LLS_THRESHOLD_RESET});
        reg_wr(LLS_THRESHOLD_ADDR, 64'hffff_ffff_ffff_0020);
        reg_wr(12'h3f5, 64'h5);
        reg_rd(LLS_THRESHOLD_ADDR, v);
        check(v, 64'h20);
        reg_rd(12'h3f5, v);
        check(v, 64'h0);
        cnt_load(2'h2);
        cnt_load(2'h3);
        model_u.run_load(4'h1, 32, 48'h0, lls_outcome_s'(12'h0), 48'h0);
        check({60'h0, ovf_seen}, 64'h0);
        for (int k = 0; k < 14; k++) begin
            cnt_load(2'h3);
            model_u.run_load(4'h1, 33, 48'h10, lls_outcome_s'(oc_tab[k]), 48'h20);
            check({60'h0, ovf_seen}, 64'h8);
            model_u.run_load(4'h2, 5, 48'h30, lls_outcome_s'(oc_tab[k]), 48'h40);
            check({63'h0, rec_seen}, 64'h0);
            check({60'h0, capture_armed}, 64'h8);
            exp_w = '{64'(34 + k), {20'h0, 40'hab_cdef_0123, code_tab[k]},
                {60'h0, code_tab[k]}, {20'h0, 40'h7f_0000_0100, code_tab[k]}};
            irq_count = 0;
            model_u.run_load(4'h3, 34 + k, {4'h0, 40'hab_cdef_0123, code_tab[k]},
                lls_outcome_s'(oc_tab[k]), {4'h0, 40'h7f_0000_0100, code_tab[k]});
            get_rec();
            repeat (4) @(negedge clock);
            check(64'(irq_count), 64'h1);
            check({60'h0, capture_armed}, 64'h0);
        end
        report_and_stop();
    end
endmodule

// ==== verif/lls_load_pipe_model.sv ====
// Behavioural model of the load pipeline and memory hierarchy feeding the sampler.
`timescale 1ns/10ps
module lls_load_pipe_model
    import lls_pkg::*;
(
    input wire logic clock,
    output logic issue_valid,
    output lls_issue_s issue,
    output logic done_valid,
    output lls_done_s done,
    output logic retire_valid,
    output lls_retire_s retire
);
    // Idle payloads start at zero and are inverted after each use so that a design which samples late sees garbage.
    initial begin
        issue_valid = 1'b0;
        done_valid = 1'b0;
        retire_valid = 1'b0;
        issue = '0;
        done = '0;
        retire = '0;
    end

    // One load: issue, data after lat cycles, retire one cycle later.
    task automatic run_load(input logic [3:0] tag, input int lat, input logic [47:0] addr,
                            input lls_outcome_s oc, input logic [47:0] ip);
        @(negedge clock);
        issue_valid = 1'b1;
        issue = '{tag: tag, address: addr};
        @(negedge clock);
        issue_valid = 1'b0;
        issue = ~issue;
        repeat (lat - 1) @(negedge clock);
        done_valid = 1'b1;
        done = '{tag: tag, outcome: oc};
        @(negedge clock);
        done_valid = 1'b0;
        done = ~done;
        retire_valid = 1'b1;
        retire = '{tag: tag, next_ip: ip};
        @(negedge clock);
        retire_valid = 1'b0;
        retire = ~retire;
    endtask
endmodule

// ==== verif/lls_sampler_sva.sv ====
// Concurrent checks on the ports of the load latency sampler.
`timescale 1ns/10ps
module lls_sampler_sva
    import lls_pkg::*;
#(
    parameter int COUNTERS = 4
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic reg_read,
    input wire logic [11:0] reg_address,
    input wire logic [63:0] reg_read_data,
    input wire logic rec_valid,
    input wire lls_rec_word_s rec_word,
    input wire logic rec_ready,
    input wire logic perf_monitor_interrupt,
    input wire logic [COUNTERS-1:0] counter_overflow,
    input wire logic [COUNTERS-1:0] capture_armed
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // ========================================================================
    // Register and record properties
    // ========================================================================
    // Words taken by the buffer, used by several properties below.
    wire logic taken = rec_valid && rec_ready;
    property p_rd_unmapped;
        reg_read && reg_address != LLS_THRESHOLD_ADDR |=> reg_read_data == 64'h0;
    endproperty
    property p_rd_upper;
        reg_read |=> reg_read_data[63:16] == 48'h0;
    endproperty
    property p_rd_stands;
        !reg_read |=> reg_read_data == 64'h0;
    endproperty
    property p_word_hold;
        rec_valid && !rec_ready |=> rec_valid && $stable(rec_word);
    endproperty
    property p_word_order;
        taken && rec_word.index != LLS_WORD_IP |=>
            rec_valid && rec_word.index == $past(rec_word.index) + 2'h1;
    endproperty
    property p_src_low4;
        rec_valid && rec_word.index == LLS_WORD_SOURCE |-> rec_word.data[63:4] == 60'h0;
    endproperty
    property p_last_irq;
        taken && rec_word.index == LLS_WORD_IP |=>
            !rec_valid ##1 perf_monitor_interrupt ##1 !perf_monitor_interrupt;
    endproperty
    property p_irq_cause;
        perf_monitor_interrupt |-> $past(taken && rec_word.index == LLS_WORD_IP, 2);
    endproperty
    property p_ovf_arms;
        counter_overflow != '0 |-> (counter_overflow & ~capture_armed) == '0;
    endproperty
    property p_rec_start;
        $rose(rec_valid) |-> rec_word.index == LLS_WORD_LATENCY;
    endproperty

    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    a_rd_upper: assert property (p_rd_upper) else $error("threshold upper bits set");
    a_rd_stands: assert property (p_rd_stands) else $error("read data held too long");
    a_word_hold: assert property (p_word_hold) else $error("record word changed");
    a_word_order: assert property (p_word_order) else $error("record word order");
    a_src_low4: assert property (p_src_low4) else $error("source field high bits");
    a_last_irq: assert property (p_last_irq) else $error("interrupt timing");
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without record");
    a_ovf_arms: assert property (p_ovf_arms) else $error("overflow did not arm");
    a_rec_start: assert property (p_rec_start) else $error("record starts mid way");

    c_record: cover property (taken && rec_word.index == LLS_WORD_IP);
    c_overflow: cover property (counter_overflow != '0);
    c_stall: cover property (rec_valid && !rec_ready);
endmodule

bind lls_load_latency_sampler lls_sampler_sva #(.COUNTERS(COUNTERS)) chk_u (
    .clock(clock),
    .reset_n(reset_n),
    .reg_read(reg_read),
    .reg_address(reg_address),
    .reg_read_data(reg_read_data),
    .rec_valid(rec_valid),
    .rec_word(rec_word),
    .rec_ready(rec_ready),
    .perf_monitor_interrupt(perf_monitor_interrupt),
    .counter_overflow(counter_overflow),
    .capture_armed(capture_armed)
);
